// File: i2hc_client_model.sv
// client-side responder: answers host operations with byte-done events
`timescale 1ns/100ps
module i2hc_client_model (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          read_dir,
  input  wire logic          kick,
  input  wire logic [3:0]    lat,
  input  i2hc_pkg::i2hc_op_t op,
  output logic               byte_rx_done,
  output logic               byte_tx_done
);
  logic [4:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h0;
      byte_rx_done <= 1'b0;
      byte_tx_done <= 1'b0;
    end else begin
      if (kick || op.send_addr || op.read_byte) cnt_reg <= {1'b0, lat} + 5'h1;
      else if (cnt_reg != 5'h0) cnt_reg <= cnt_reg - 5'h1;
      byte_rx_done <= (cnt_reg == 5'h1) && read_dir;
      byte_tx_done <= (cnt_reg == 5'h1) && !read_dir;
    end
  end
endmodule : i2hc_client_model

// File: i2hc_pkg.sv
// package: register map, fields and types of the i2c host command block
package i2hc_pkg;
  localparam logic [3:0] IDX_CMD_CTRL = 4'h4;
  localparam logic [3:0] IDX_SYNCBUSY = 4'h7;
  localparam logic [3:0] IDX_DBG_CTRL = 4'h8;
  localparam logic [3:0] IDX_SCL_DIV  = 4'ha;
  localparam logic [3:0] IDX_IEN_CLR  = 4'hc;
  localparam logic [3:0] IDX_IEN_SET  = 4'hd;
  localparam logic [3:0] IDX_FLAGS    = 4'he;
  localparam int ADDR_W = 6;
  localparam int POS_CMD       = 16;
  localparam int POS_ACK_ACT   = 18;
  localparam int POS_QUICK_COMMAND_ENABLE      = 9;
  localparam int POS_SMART_READ_ACK_ENABLE      = 8;
  localparam int POS_HALT_DBG  = 0;
  localparam int POS_CLIENT    = 1;
  localparam int POS_HOST      = 0;
  localparam int POS_SYSOP     = 2;
  localparam logic [15:0] RST_SCL_DIV = 16'h0000;
  localparam logic [7:0]  RST_DBG     = 8'h00;
  localparam logic [1:0]  RST_IEN     = 2'h0;
  localparam int SYNC_TIME_NS = 8;
  localparam int CLK_NS       = 4;
  localparam int SYNC_CYCLES  = (SYNC_TIME_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_RSTRT = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } i2hc_cmd_t;
  typedef struct packed {
    logic ack;
    logic nack;
    logic rstart;
    logic send_addr;
    logic read_byte;
    logic stop;
  } i2hc_op_t;
endpackage : i2hc_pkg

// File: i2hc_tb.sv
// self-checking testbench of the i2c host command block
`timescale 1ns/100ps
module testbench;
  localparam int SYNC_N = 3;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [5:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               periph_enabled, read_dir, rx_done, tx_done, debug_halt, kick;
  logic [2:0]         ev;
  logic [3:0]         lat;
  i2hc_pkg::i2hc_op_t op;
  logic               scl_hold, scl_gen, qce, busy, irq, busy_seen;
  logic [5:0]         op_seen, e;
  int                 bad_count, num_checks, hi, lo, n;
  i2hc_top #(.SYNC_N(SYNC_N)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_enabled(periph_enabled),
    .read_dir(read_dir), .byte_rx_done(rx_done), .byte_tx_done(tx_done),
    .addr_write(ev[0]), .data_read(ev[1]), .data_write(ev[2]), .debug_halt(debug_halt),
    .op(op), .scl_hold(scl_hold), .scl_gen(scl_gen), .quick_command_enable(qce),
    .system_operation_busy(busy), .irq(irq));
  i2hc_client_model client (.pclk(pclk), .presetn(presetn), .read_dir(read_dir),
    .kick(kick), .lat(lat), .op(op), .byte_rx_done(rx_done), .byte_tx_done(tx_done));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, 1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1 op_seen = op;
    busy_seen = busy;
  endtask : apb
  task pulse(input logic [2:0] k);
    @(posedge pclk);
    ev <= k;
    @(posedge pclk);
    ev <= 3'h0;
    #1 op_seen = op;
    busy_seen = busy;
  endtask : pulse
  task arm;
    if (scl_hold !== 1'b1) begin
      @(posedge pclk);
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
    end
    n = 0;
    while (scl_hold !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(scl_hold, 1);
  endtask : arm
  task meas;
    n = 0;
    while (scl_gen === 1'b1 && n < 900) begin
      @(posedge pclk);
      n++;
    end
    while (scl_gen !== 1'b1 && n < 900) begin
      @(posedge pclk);
      n++;
    end
    hi = 0;
    lo = 0;
    do begin
      hi++;
      @(posedge pclk);
    end while (scl_gen === 1'b1 && hi < 300);
    do begin
      lo++;
      @(posedge pclk);
    end while (scl_gen === 1'b0 && lo < 300);
  endtask : meas
  task busy_run;
    chk(busy_seen, 1);
    repeat (SYNC_N) @(posedge pclk);
    #1 chk(busy, 0);
  endtask : busy_run
  initial begin
    {psel, penable, pwrite, paddr, pwdata, periph_enabled, read_dir} = '0;
    {debug_halt, kick, ev, lat, bad_count, num_checks} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, i2hc_pkg::IDX_DBG_CTRL, 0); chk(rd, 32'h0000_0000);
    apb(0, i2hc_pkg::IDX_SCL_DIV, 0); chk(rd, 32'h0000_0000);
    apb(0, 4'hf, 0);
    chk(er, 1);
    chk(rd, 32'h0000_0000);
    apb(1, i2hc_pkg::IDX_IEN_SET, 32'h0000_0003);
    apb(1, i2hc_pkg::IDX_IEN_CLR, 32'h0000_0001);
    apb(1, i2hc_pkg::IDX_IEN_CLR, 32'h0000_0000);
    apb(0, i2hc_pkg::IDX_IEN_CLR, 0); chk(rd, 32'h0000_0002);
    apb(0, i2hc_pkg::IDX_IEN_SET, 0); chk(rd, 32'h0000_0002);
    apb(0, i2hc_pkg::IDX_IEN_CLR, 0); chk(rd, 32'h0000_0002);
    apb(1, i2hc_pkg::IDX_SCL_DIV, 32'h0000_0102);
    meas();
    chk(hi, 3);
    chk(lo, 2);
    apb(1, i2hc_pkg::IDX_SCL_DIV, 32'h0000_0004);
    meas();
    chk(hi, 5);
    chk(lo, 5);
    apb(1, i2hc_pkg::IDX_DBG_CTRL, 32'h0000_0001);
    debug_halt <= 1'b1;
    repeat (6) @(posedge pclk);
    e[0] = scl_gen;
    repeat (25) @(posedge pclk);
    chk(scl_gen, e[0]);
    apb(1, i2hc_pkg::IDX_DBG_CTRL, 32'h0000_0000);
    meas();
    chk(hi, 5);
    chk(lo, 5);
    debug_halt <= 1'b0;
    apb(1, i2hc_pkg::IDX_CMD_CTRL, 32'h0004_0300);
    apb(0, i2hc_pkg::IDX_CMD_CTRL, 0); chk(rd, 32'h0004_0300);
    chk(qce, 1);
    read_dir <= 1'b1;
    arm();
    apb(0, i2hc_pkg::IDX_FLAGS, 0); chk(rd, 32'h0000_0002);
    chk(irq, 1);
    pulse(3'h2); chk(op_seen, 6'h30);
    apb(1, i2hc_pkg::IDX_CMD_CTRL, 32'h0000_0000);
    periph_enabled <= 1'b1;
    apb(1, i2hc_pkg::IDX_SCL_DIV, 32'h0000_ffff);
    apb(0, i2hc_pkg::IDX_SCL_DIV, 0); chk(rd, 32'h0000_0004);
    for (int d = 0; d < 2; d++) begin
      lat <= d ? 4'h9 : 4'h0;
      for (int c = 0; c < 4; c++) begin
        read_dir <= d[0];
        arm();
        e = d ? {1'b1, c[0], c == 1, c == 1, c == 2, c == 3} : {2'b00, c == 1, c == 1, 1'b0, c == 3};
        if (c == 0) e = 6'h00;
        apb(1, i2hc_pkg::IDX_CMD_CTRL, {13'h0000, d[0] & c[0], c[1:0], 16'h0000});
        chk(op_seen, e);
        if (e != 6'h00) busy_run();
      end
    end
    apb(0, i2hc_pkg::IDX_CMD_CTRL, 0); chk(rd, 32'h0004_0000);
    read_dir <= 1'b0;
    arm();
    apb(0, i2hc_pkg::IDX_FLAGS, 0); chk(rd, 32'h0000_0001);
    chk(irq, 0);
    pulse(3'h1); chk(op_seen, 6'h0c);
    busy_run();
    arm();
    pulse(3'h4); chk(scl_hold, 0);
    apb(1, i2hc_pkg::IDX_CMD_CTRL, 32'h0003_0000); chk(op_seen, 6'h00);
    end_sim();
  end
endmodule : testbench

// File: i2hc_top.sv
// i2c host command, scl divider and interrupt enable block with apb registers
`timescale 1ns/100ps
module i2hc_top #(
  parameter int SYNC_N = i2hc_pkg::SYNC_CYCLES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [i2hc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      periph_enabled,
  input  wire logic                      read_dir,
  input  wire logic                      byte_rx_done,
  input  wire logic                      byte_tx_done,
  input  wire logic                      addr_write,
  input  wire logic                      data_read,
  input  wire logic                      data_write,
  input  wire logic                      debug_halt,
  output i2hc_pkg::i2hc_op_t             op,
  output logic                           scl_hold,
  output logic                           scl_gen,
  output logic                           quick_command_enable,
  output logic                           system_operation_busy,
  output logic                           irq
);
  initial begin
    if (SYNC_N < 1 || SYNC_N > 255) $error("SYNC_N out of range");
  end

  // apb decode
  wire logic [3:0] idx = paddr[i2hc_pkg::ADDR_W-1:2];
  wire logic       wr  = psel && penable && pwrite;
  wire logic       rd  = psel && penable && !pwrite;
  wire logic       hit_cmd  = idx == i2hc_pkg::IDX_CMD_CTRL;
  wire logic       hit_sync = idx == i2hc_pkg::IDX_SYNCBUSY;
  wire logic       hit_dbg  = idx == i2hc_pkg::IDX_DBG_CTRL;
  wire logic       hit_div  = idx == i2hc_pkg::IDX_SCL_DIV;
  wire logic       hit_iclr = idx == i2hc_pkg::IDX_IEN_CLR;
  wire logic       hit_iset = idx == i2hc_pkg::IDX_IEN_SET;
  wire logic       hit_flg  = idx == i2hc_pkg::IDX_FLAGS;
  wire logic       mapped   = hit_cmd || hit_sync || hit_dbg || hit_div
                              || hit_iclr || hit_iset || hit_flg;
  wire logic       aligned  = paddr[1:0] == 2'b00;
  wire logic       ok       = mapped && aligned;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !ok;

  // registers
  logic        ack_action_reg;
  logic        quick_command_enable_reg;
  logic        smart_read_ack_enable_reg;
  logic        halt_on_debug_reg;
  logic [15:0] scl_div_reg;
  logic [1:0]  ien_reg;
  logic [1:0]  ien_next;
  logic        client_on_bus_flag;
  logic        host_on_bus_flag;
  logic [7:0]  sync_cnt_reg;
  i2hc_pkg::i2hc_op_t op_next;

  wire logic wr_cmd  = wr && ok && hit_cmd;
  wire logic wr_dbg  = wr && ok && hit_dbg;
  wire logic wr_div  = wr && ok && hit_div && !periph_enabled;
  wire logic wr_ctl  = wr_cmd && !periph_enabled;
  wire logic wr_iclr = wr && ok && hit_iclr;
  wire logic wr_iset = wr && ok && hit_iset;
  wire logic wr_flg  = wr && ok && hit_flg;

  // command decode, ack action taken from the same write
  wire logic [1:0] cmd_code = pwdata[i2hc_pkg::POS_CMD +: 2];
  wire logic       ack_new  = pwdata[i2hc_pkg::POS_ACK_ACT];
  wire logic       on_bus   = client_on_bus_flag || host_on_bus_flag;
  wire logic       cmd_go   = wr_cmd && cmd_code != 2'(i2hc_pkg::CMD_NONE)
                              && on_bus;
  wire logic       is_rst   = cmd_code == 2'(i2hc_pkg::CMD_RSTRT);
  wire logic       is_read  = cmd_code == 2'(i2hc_pkg::CMD_READ);
  wire logic       is_stop  = cmd_code == 2'(i2hc_pkg::CMD_STOP);
  wire logic       smart_go = data_read && smart_read_ack_enable_reg && on_bus;
  wire logic       addr_go  = addr_write && on_bus;
  wire logic       flag_rel = cmd_go || smart_go || addr_go || data_write;

  always_comb begin
    op_next = '0;
    if (cmd_go) begin
      op_next.ack       = read_dir && (is_rst || is_stop || is_read);
      op_next.nack      = read_dir && ack_new;
      op_next.rstart    = is_rst;
      op_next.send_addr = is_rst;
      op_next.read_byte = is_read && read_dir;
      op_next.stop      = is_stop;
    end else if (smart_go) begin
      op_next.ack  = read_dir;
      op_next.nack = read_dir && ack_action_reg;
    end else if (addr_go) begin
      op_next.rstart    = 1'b1;
      op_next.send_addr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= '0;
    end else begin
      op <= op_next;
    end
  end

  // control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_action_reg <= 1'b0;
      quick_command_enable_reg       <= 1'b0;
      smart_read_ack_enable_reg       <= 1'b0;
    end else if (wr_cmd) begin
      ack_action_reg <= ack_new;
      if (wr_ctl) begin
        quick_command_enable_reg <= pwdata[i2hc_pkg::POS_QUICK_COMMAND_ENABLE];
        smart_read_ack_enable_reg <= pwdata[i2hc_pkg::POS_SMART_READ_ACK_ENABLE];
      end
    end
  end
  assign quick_command_enable = quick_command_enable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_on_debug_reg <= i2hc_pkg::RST_DBG[i2hc_pkg::POS_HALT_DBG];
    end else if (wr_dbg) begin
      halt_on_debug_reg <= pwdata[i2hc_pkg::POS_HALT_DBG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_div_reg <= i2hc_pkg::RST_SCL_DIV;
    end else if (wr_div) begin
      scl_div_reg <= pwdata[15:0];
    end
  end

  // one shared enable state behind set and clear views
  always_comb begin
    ien_next = ien_reg;
    if (wr_iclr) begin
      ien_next = ien_reg & ~pwdata[1:0];
    end else if (wr_iset) begin
      ien_next = ien_reg | pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_reg <= i2hc_pkg::RST_IEN;
    end else begin
      ien_reg <= ien_next;
    end
  end

  // bus-on flags: set wins over any clear
  wire logic clr_client = flag_rel || (wr_flg && pwdata[i2hc_pkg::POS_CLIENT]);
  wire logic clr_host   = flag_rel || (wr_flg && pwdata[i2hc_pkg::POS_HOST]);
  wire logic set_client = byte_rx_done && read_dir;
  wire logic set_host   = byte_tx_done && !read_dir;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      client_on_bus_flag <= 1'b0;
      host_on_bus_flag   <= 1'b0;
    end else begin
      client_on_bus_flag <= set_client || (client_on_bus_flag && !clr_client);
      host_on_bus_flag   <= set_host || (host_on_bus_flag && !clr_host);
    end
  end
  assign scl_hold = client_on_bus_flag || host_on_bus_flag;
  assign irq = (client_on_bus_flag && ien_reg[i2hc_pkg::POS_CLIENT])
               || (host_on_bus_flag && ien_reg[i2hc_pkg::POS_HOST]);

  // system operation busy for the crossing time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt_reg <= 8'h00;
    end else if (cmd_go || addr_go) begin
      sync_cnt_reg <= 8'(SYNC_N);
    end else if (sync_cnt_reg != 8'h00) begin
      sync_cnt_reg <= sync_cnt_reg - 8'h01;
    end
  end
  assign system_operation_busy = sync_cnt_reg != 8'h00;

  // debug halt input synchroniser
  logic dbg_meta_reg;
  logic dbg_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_meta_reg <= 1'b0;
      dbg_sync_reg <= 1'b0;
    end else begin
      dbg_meta_reg <= debug_halt;
      dbg_sync_reg <= dbg_meta_reg;
    end
  end

  // scl divider
  wire logic [7:0] div_hi  = scl_div_reg[7:0];
  wire logic [7:0] div_lo  = (scl_div_reg[15:8] != 8'h00) ? scl_div_reg[15:8]
                                                          : scl_div_reg[7:0];
  wire logic       halted  = halt_on_debug_reg && dbg_sync_reg;
  logic [7:0] baud_cnt_reg;
  logic       scl_gen_reg;
  wire logic [7:0] phase_end = scl_gen_reg ? div_hi : div_lo;
  wire logic       phase_done = baud_cnt_reg >= phase_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= 8'h00;
      scl_gen_reg  <= 1'b1;
    end else if (!halted) begin
      if (phase_done) begin
        baud_cnt_reg <= 8'h00;
        scl_gen_reg  <= !scl_gen_reg;
      end else begin
        baud_cnt_reg <= baud_cnt_reg + 8'h01;
      end
    end
  end
  assign scl_gen = scl_gen_reg;

  // read mux, command field always reads zero
  wire logic [31:0] rd_cmd  = {13'h0000, ack_action_reg, 2'b00, 6'h00,
                               quick_command_enable_reg, smart_read_ack_enable_reg, 8'h00};
  wire logic [31:0] rd_sync = {29'h0000_0000, system_operation_busy, 2'b00};
  wire logic [31:0] rd_dbg  = {31'h0000_0000, halt_on_debug_reg};
  wire logic [31:0] rd_div  = {16'h0000, scl_div_reg};
  wire logic [31:0] rd_ien  = {30'h0000_0000, ien_reg};
  wire logic [31:0] rd_flg  = {30'h0000_0000, client_on_bus_flag, host_on_bus_flag};
  wire logic [31:0] rd_val  = !ok                 ? 32'h0000_0000 :
                              hit_cmd             ? rd_cmd :
                              hit_sync            ? rd_sync :
                              hit_dbg             ? rd_dbg :
                              hit_div             ? rd_div :
                              (hit_iclr||hit_iset) ? rd_ien : rd_flg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_val;
    end
  end

  // checks
  sequence cmd_write_s;
    wr_cmd && on_bus && cmd_code != 2'b00;
  endsequence
  sequence busy_run_s;
    system_operation_busy [*1];
  endsequence

  cmd_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cmd[17:16] == 2'b00) else $error("command field read nonzero");
  write_no_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && !read_dir) |=> !op.ack && !op.read_byte)
    else $error("ack action in write mode");
  ack_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && read_dir) |=> op.nack == $past(ack_new) && ack_action_reg == op.nack)
    else $error("ack action not updated first");
  off_bus_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cmd && !on_bus && !addr_write && !data_read) |=> op == '0)
    else $error("command acted off bus");
  restart_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && is_rst) |=> op.rstart && op.send_addr)
    else $error("restart missing");
  busy_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write_s |=> busy_run_s ##SYNC_N !system_operation_busy)
    else $error("busy timing wrong");
  stop_any_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && is_stop) |=> op.stop && !op.rstart)
    else $error("stop missing");
  enable_shared_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_iclr && pwdata[1]) |=> !ien_reg[1]) else $error("enable clear failed");
  enable_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_iset && pwdata[0]) |=> ien_reg[0]) else $error("enable set failed");
  flag_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_client |=> client_on_bus_flag && scl_hold) else $error("client flag lost");
  host_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_host |=> host_on_bus_flag) else $error("host flag lost");
  irq_link_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == ((client_on_bus_flag && ien_reg[1]) || (host_on_bus_flag && ien_reg[0])))
    else $error("irq mismatch");
  halt_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (halted && $past(halted)) |-> $stable(baud_cnt_reg) && $stable(scl_gen_reg))
    else $error("divider ran while halted");

  // event steps: smart read and address write with no command in the same cycle
  sequence smart_read_s;
    smart_go && !cmd_go && read_dir;
  endsequence
  sequence addr_only_s;
    addr_go && !cmd_go && !smart_go;
  endsequence

  smart_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    smart_read_s |=> op.ack && op.nack == $past(ack_action_reg))
    else $error("smart read ack missing");
  addr_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_only_s |=> op.rstart && op.send_addr && !op.stop)
    else $error("address write restart missing");
  none_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cmd && cmd_code == 2'b00 && !smart_go && !addr_go) |=> op == '0)
    else $error("code zero acted");
  write_read_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && is_read && !read_dir) |=> op == '0)
    else $error("read code acted in write mode");
  write_no_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && !read_dir) |=> !op.nack)
    else $error("nack in write mode");
  quick_command_enable_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> quick_command_enable == $past(pwdata[i2hc_pkg::POS_QUICK_COMMAND_ENABLE]))
    else $error("quick command bit not taken");
  clear_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_iclr && !pwdata[0]) |=> ien_reg[0] == $past(ien_reg[0]))
    else $error("enable clear zero changed state");
  halt_off_runs_a: assert property (@(posedge pclk) disable iff (!presetn)
    !halted |=> (baud_cnt_reg != $past(baud_cnt_reg)) || (scl_gen_reg != $past(scl_gen_reg)))
    else $error("divider stopped while running");
  client_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_rel && !set_client) |=> !client_on_bus_flag)
    else $error("client flag not released");
  host_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_rel && !set_host) |=> !host_on_bus_flag)
    else $error("host flag not released");
  div_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_div && periph_enabled) |=> scl_div_reg == $past(scl_div_reg))
    else $error("divider written while enabled");
endmodule : i2hc_top
